//--- tsh_pkg.sv
// package: constants, types and state record of the task state segment handler
package tsh_pkg;

	// ***********************************
	// state segment layout (byte offsets and word step counts)
	// ***********************************
	localparam logic [7:0] SEG_LINK = 8'h00;
	localparam logic [7:0] SEG_STK = 8'h04;
	localparam logic [7:0] SEG_IP = 8'h20;
	localparam logic [7:0] SEG_LTBL = 8'h60;
	localparam logic [7:0] SEG_TRAP = 8'h64;
	localparam logic [4:0] SAVE_LAST = 5'h0f;
	localparam logic [4:0] LOAD_LAST = 5'h08;
	localparam logic [4:0] LOAD_STK_N = 5'h07;
	localparam logic [4:0] SAVE_GPR0 = 5'h02;
	localparam logic [4:0] SAVE_SEL0 = 5'h0a;

	// ***********************************
	// descriptor and task register values
	// ***********************************
	localparam logic [3:0] TYPE_AVAIL = 4'h9;
	localparam logic [3:0] TYPE_BUSY = 4'hb;
	localparam logic [19:0] SEG_MIN_LIMIT = 20'h00067;
	localparam logic [31:0] TR_LIMIT_RST = 32'h00000fff;
	localparam logic [15:0] TR_SEL_RST = 16'h0000;
	localparam logic [31:0] TR_BASE_RST = 32'h00000000;
	localparam int SEL_TBL_BIT = 2;

	// ***********************************
	// register byte offsets and bit positions
	// ***********************************
	localparam logic [7:0] R_CTRL = 8'h00;
	localparam logic [7:0] R_STATUS = 8'h04;
	localparam logic [7:0] R_NEWSEL = 8'h08;
	localparam logic [7:0] R_LVL = 8'h0c;
	localparam logic [7:0] R_GTBL = 8'h10;
	localparam logic [7:0] R_TRSEL = 8'h14;
	localparam logic [7:0] R_TRBASE = 8'h18;
	localparam logic [7:0] R_TRLIM = 8'h1c;
	localparam logic [7:0] R_LDTSEL = 8'h20;
	localparam logic [7:0] R_PAGE = 8'h24;
	localparam logic [7:0] R_IOMAP = 8'h28;
	localparam logic [7:0] R_SEGCHK = 8'h2c;
	localparam logic [7:0] R_IOCHK = 8'h30;
	localparam logic [7:0] R_GPR = 8'h40;
	localparam logic [7:0] R_SEL = 8'h60;
	localparam logic [7:0] R_FLAGS = 8'h78;
	localparam logic [7:0] R_IP = 8'h7c;
	localparam logic [7:0] R_STK = 8'h80;
	localparam logic [7:0] R_STK_END = 8'h98;
	localparam int CTRL_GO = 0;
	localparam int CTRL_KIND = 1;
	localparam int CTRL_M64 = 3;
	localparam int ST_BUSY = 0;
	localparam int ST_PROT = 1;
	localparam int ST_BADSEG = 2;
	localparam int ST_DBG = 3;
	localparam int ST_IO = 4;

	typedef enum logic [1:0] {
		K_JMP = 2'h0,
		K_CALL = 2'h1,
		K_INT = 2'h2,
		K_RET = 2'h3
	} tsh_kind_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_LINK_RD = 3'h1,
		S_DESC_LO = 3'h3,
		S_DESC_HI = 3'h2,
		S_CHECK = 3'h6,
		S_SAVE = 3'h7,
		S_LINK_WR = 3'h5,
		S_LOAD = 3'h4
	} tsh_fsm_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} tsh_mem_t;

	typedef struct packed {
		logic prot;
		logic badseg;
		logic dbg;
	} tsh_flt_t;

	typedef struct packed {
		tsh_fsm_t fsm;
		logic [4:0] cnt;
		logic go;
		tsh_kind_t kind;
		logic m64;
		logic [1:0] lvl;
		logic [15:0] newsel;
		logic [31:0] gtbl_base;
		logic [31:0] dlo;
		logic [31:0] dhi;
		logic [31:0] new_base;
		logic [31:0] new_limit;
		logic [15:0] tr_sel;
		logic [31:0] tr_base;
		logic [31:0] tr_limit;
		logic [15:0] ltbl_sel;
		logic [31:0] page_base;
		logic [15:0] iomap;
		logic [5:0][31:0] stk;
		logic [7:0][31:0] gpr;
		logic [5:0][15:0] sel;
		logic [31:0] flags;
		logic [31:0] ip;
		logic [4:0] stat;
		tsh_flt_t flt;
		logic ap_pend;
		logic ap_write;
		logic [7:0] ap_addr;
		logic hready;
		logic [31:0] hrdata;
		tsh_mem_t mem;
	} tsh_state_t;

endpackage

//--- tsh_task_state_segment_handler.sv
// module: task state segment switch engine with ahb-lite register slave
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module tsh_task_state_segment_handler (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output tsh_pkg::tsh_mem_t mem_o,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output tsh_pkg::tsh_flt_t fault_o
);
	import tsh_pkg::*;

	tsh_state_t st_q;
	tsh_state_t st_d;
	logic hresp_q;

	// ***********************************
	// descriptor decode
	// ***********************************
	logic [3:0] d_type;
	logic d_sys;
	logic [1:0] d_lvl;
	logic d_gran;
	logic [19:0] d_lim;
	logic [31:0] d_base;
	logic bad_type;
	logic busy_bad;
	logic priv_bad;
	logic lim_bad;

	always_comb begin
		d_type = st_q.dhi[11:8];
		d_sys = st_q.dhi[12];
		d_lvl = st_q.dhi[14:13];
		d_gran = st_q.dhi[23];
		d_lim = {st_q.dhi[19:16], st_q.dlo[15:0]};
		d_base = {st_q.dhi[31:24], st_q.dhi[7:0], st_q.dlo[31:16]};
		bad_type = d_sys || !(d_type == TYPE_AVAIL || d_type == TYPE_BUSY);
		busy_bad = (st_q.kind == K_RET) ? (d_type != TYPE_BUSY)
			: (d_type == TYPE_BUSY);
		priv_bad = (st_q.kind == K_JMP || st_q.kind == K_CALL)
			&& (st_q.lvl > d_lvl);
		lim_bad = !d_gran && (d_lim < SEG_MIN_LIMIT);
	end

	// ***********************************
	// register read mux
	// ***********************************
	function automatic logic [31:0] rd_reg(input tsh_state_t s,
		input logic [7:0] a);
		logic [31:0] v;
		v = 32'h00000000;
		if (a >= R_GPR && a < R_SEL) begin
			v = s.gpr[3'(a[4:2])];
		end else if (a >= R_SEL && a < R_FLAGS) begin
			v = {16'h0000, s.sel[3'((a - R_SEL) >> 2)]};
		end else if (a >= R_STK && a < R_STK_END) begin
			v = s.stk[3'((a - R_STK) >> 2)];
		end else begin
			case (a)
				R_CTRL: v = {28'h0000000, s.m64, s.kind, 1'b0};
				R_STATUS: v = {27'h0000000, s.stat};
				R_NEWSEL: v = {16'h0000, s.newsel};
				R_LVL: v = {30'h00000000, s.lvl};
				R_GTBL: v = s.gtbl_base;
				R_TRSEL: v = {16'h0000, s.tr_sel};
				R_TRBASE: v = s.tr_base;
				R_TRLIM: v = s.tr_limit;
				R_LDTSEL: v = {16'h0000, s.ltbl_sel};
				R_PAGE: v = s.page_base;
				R_IOMAP: v = {16'h0000, s.iomap};
				R_FLAGS: v = s.flags;
				R_IP: v = s.ip;
				default: v = 32'h00000000;
			endcase
		end
		return v;
	endfunction

	// ***********************************
	// next state
	// ***********************************
	always_comb begin
		st_d = st_q;
		st_d.go = 1'b0;
		st_d.flt = '0;
		// bus address phase
		if (hsel && htrans[1] && hready && st_q.hready) begin
			st_d.ap_pend = 1'b1;
			st_d.ap_write = hwrite;
			st_d.ap_addr = haddr[7:0];
			st_d.hready = 1'b0;
		end
		// bus data phase, one wait state
		if (st_q.ap_pend) begin
			st_d.ap_pend = 1'b0;
			st_d.hready = 1'b1;
			if (!st_q.ap_write) begin
				st_d.hrdata = rd_reg(st_q, st_q.ap_addr);
			end else if (st_q.ap_addr >= R_GPR && st_q.ap_addr < R_SEL) begin
				st_d.gpr[3'(st_q.ap_addr[4:2])] = hwdata;
			end else if (st_q.ap_addr >= R_SEL && st_q.ap_addr < R_FLAGS) begin
				st_d.sel[3'((st_q.ap_addr - R_SEL) >> 2)] = hwdata[15:0];
			end else begin
				case (st_q.ap_addr)
					R_CTRL: begin
						if (st_q.fsm == S_IDLE) begin
							st_d.go = hwdata[CTRL_GO];
							st_d.kind = tsh_kind_t'(hwdata[CTRL_KIND +: 2]);
							st_d.m64 = hwdata[CTRL_M64];
						end
					end
					R_STATUS: st_d.stat = st_q.stat & ~hwdata[4:0];
					R_NEWSEL: st_d.newsel = hwdata[15:0];
					R_LVL: st_d.lvl = hwdata[1:0];
					R_GTBL: st_d.gtbl_base = hwdata;
					R_SEGCHK: begin
						if (!hwdata[4] && (hwdata[3:0] == TYPE_AVAIL
							|| hwdata[3:0] == TYPE_BUSY)) begin
							st_d.flt.prot = 1'b1;
						end
					end
					R_IOCHK: begin
						if ({16'h0000, st_q.iomap} + {16'h0000, hwdata[15:0]}
							> st_q.tr_limit) begin
							st_d.stat[ST_IO] = 1'b1;
						end
					end
					R_FLAGS: st_d.flags = hwdata;
					R_IP: st_d.ip = hwdata;
					default: st_d.hrdata = st_q.hrdata;
				endcase
			end
		end
		// switch engine
		case (st_q.fsm)
			S_IDLE: begin
				if (st_q.go) begin
					if (st_q.m64) begin
						st_d.flt.prot = 1'b1;
					end else if (st_q.kind == K_RET) begin
						st_d.fsm = S_LINK_RD;
					end else if (st_q.newsel[SEL_TBL_BIT]) begin
						st_d.flt.prot = 1'b1;
					end else begin
						st_d.fsm = S_DESC_LO;
					end
				end
			end
			S_LINK_RD: begin
				if (!st_q.mem.req) begin
					st_d.mem = '{1'b1, 1'b0, st_q.tr_base + 32'(SEG_LINK), 32'h0};
				end else if (mem_ack) begin
					st_d.mem.req = 1'b0;
					st_d.newsel = mem_rdata[15:0];
					if (mem_rdata[SEL_TBL_BIT]) begin
						st_d.flt.badseg = 1'b1;
						st_d.fsm = S_IDLE;
					end else begin
						st_d.fsm = S_DESC_LO;
					end
				end
			end
			S_DESC_LO, S_DESC_HI: begin
				if (!st_q.mem.req) begin
					st_d.mem = '{1'b1, 1'b0, st_q.gtbl_base
						+ {16'h0000, st_q.newsel[15:3], 3'h0}
						+ ((st_q.fsm == S_DESC_HI) ? 32'h4 : 32'h0), 32'h0};
				end else if (mem_ack) begin
					st_d.mem.req = 1'b0;
					if (st_q.fsm == S_DESC_LO) begin
						st_d.dlo = mem_rdata;
						st_d.fsm = S_DESC_HI;
					end else begin
						st_d.dhi = mem_rdata;
						st_d.fsm = S_CHECK;
					end
				end
			end
			S_CHECK: begin
				st_d.new_base = d_base;
				st_d.new_limit = d_gran ? {d_lim, 12'hfff} : {12'h000, d_lim};
				st_d.cnt = 5'h00;
				if (bad_type || busy_bad) begin
					st_d.flt.prot = (st_q.kind != K_RET);
					st_d.flt.badseg = (st_q.kind == K_RET);
					st_d.fsm = S_IDLE;
				end else if (priv_bad) begin
					st_d.flt.prot = 1'b1;
					st_d.fsm = S_IDLE;
				end else if (lim_bad) begin
					st_d.flt.badseg = 1'b1;
					st_d.fsm = S_IDLE;
				end else begin
					st_d.fsm = S_SAVE;
				end
			end
			S_SAVE: begin
				if (!st_q.mem.req) begin
					st_d.mem.req = 1'b1;
					st_d.mem.we = 1'b1;
					st_d.mem.addr = st_q.tr_base + 32'(SEG_IP)
						+ {25'h0000000, st_q.cnt, 2'h0};
					if (st_q.cnt == 5'h00) begin
						st_d.mem.wdata = st_q.ip;
					end else if (st_q.cnt == 5'h01) begin
						st_d.mem.wdata = st_q.flags;
					end else if (st_q.cnt < SAVE_SEL0) begin
						st_d.mem.wdata = st_q.gpr[3'(st_q.cnt - SAVE_GPR0)];
					end else begin
						st_d.mem.wdata = {16'h0000,
							st_q.sel[3'(st_q.cnt - SAVE_SEL0)]};
					end
				end else if (mem_ack) begin
					st_d.mem.req = 1'b0;
					st_d.cnt = st_q.cnt + 5'h01;
					if (st_q.cnt == SAVE_LAST) begin
						st_d.cnt = 5'h00;
						st_d.fsm = (st_q.kind == K_CALL || st_q.kind == K_INT)
							? S_LINK_WR : S_LOAD;
					end
				end
			end
			S_LINK_WR: begin
				if (!st_q.mem.req) begin
					st_d.mem = '{1'b1, 1'b1, st_q.new_base + 32'(SEG_LINK),
						{16'h0000, st_q.tr_sel}};
				end else if (mem_ack) begin
					st_d.mem.req = 1'b0;
					st_d.fsm = S_LOAD;
				end
			end
			S_LOAD: begin
				if (!st_q.mem.req) begin
					st_d.mem.req = 1'b1;
					st_d.mem.we = 1'b0;
					st_d.mem.wdata = 32'h00000000;
					st_d.mem.addr = (st_q.cnt < LOAD_STK_N)
						? st_q.new_base + 32'(SEG_STK) + {25'h0, st_q.cnt, 2'h0}
						: st_q.new_base + 32'(SEG_LTBL)
						+ {25'h0, st_q.cnt - LOAD_STK_N, 2'h0};
				end else if (mem_ack) begin
					st_d.mem.req = 1'b0;
					st_d.cnt = st_q.cnt + 5'h01;
					if (st_q.cnt < 5'h06) begin
						st_d.stk[3'(st_q.cnt)] = mem_rdata;
					end else if (st_q.cnt == 5'h06) begin
						st_d.page_base = mem_rdata;
					end else if (st_q.cnt == LOAD_STK_N) begin
						st_d.ltbl_sel = mem_rdata[15:0];
					end else begin
						st_d.iomap = mem_rdata[31:16];
						st_d.flt.dbg = mem_rdata[0];
						st_d.tr_sel = st_q.newsel;
						st_d.tr_base = st_q.new_base;
						st_d.tr_limit = st_q.new_limit;
						st_d.fsm = S_IDLE;
					end
				end
			end
			default: st_d.fsm = S_IDLE;
		endcase
		st_d.stat[ST_BUSY] = (st_d.fsm != S_IDLE);
		// hardware set wins over software clear
		if (st_d.flt.prot) begin
			st_d.stat[ST_PROT] = 1'b1;
		end
		if (st_d.flt.badseg) begin
			st_d.stat[ST_BADSEG] = 1'b1;
		end
		if (st_d.flt.dbg) begin
			st_d.stat[ST_DBG] = 1'b1;
		end
	end

	// ***********************************
	// state register
	// ***********************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
			st_q.tr_sel <= TR_SEL_RST;
			st_q.tr_base <= TR_BASE_RST;
			st_q.tr_limit <= TR_LIMIT_RST;
			st_q.hready <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			st_q <= st_d;
			hresp_q <= 1'b0;
		end
	end

	assign hreadyout = st_q.hready;
	assign hresp = hresp_q;
	assign hrdata = st_q.hrdata;
	assign mem_o = st_q.mem;
	assign fault_o = st_q.flt;

	// ***********************************
	// assertions
	// ***********************************
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_reset_task_reg: assert property (@(posedge hclk) $rose(hresetn) |->
		st_q.tr_limit == TR_LIMIT_RST && st_q.tr_base == TR_BASE_RST
		&& st_q.tr_sel == TR_SEL_RST)
		else $error("task register not at reset value");
	a_ltbl_prot_fault: assert property (st_q.fsm == S_IDLE && st_q.go
		&& !st_q.m64 && st_q.kind != K_RET && st_q.newsel[SEL_TBL_BIT] |=>
		fault_o.prot && st_q.fsm == S_IDLE)
		else $error("local table selector did not fault");
	a_mode64_refuse: assert property (st_q.fsm == S_IDLE && st_q.go && st_q.m64
		|=> fault_o.prot ##1 st_q.fsm == S_IDLE)
		else $error("switch started in 64-bit mode");
	a_save_address: assert property (st_q.fsm == S_SAVE && st_q.mem.req |->
		st_q.mem.we && st_q.mem.addr == st_q.tr_base + 32'h20
		+ {25'h0, st_q.cnt, 2'h0})
		else $error("save address not contiguous");
	a_sel_upper_zero: assert property (st_q.fsm == S_SAVE && st_q.mem.req
		&& st_q.cnt >= 5'h0a |-> st_q.mem.wdata[31:16] == 16'h0000)
		else $error("selector upper half not zero");
	a_gpr_save_data: assert property (st_q.fsm == S_SAVE && st_q.mem.req
		&& st_q.cnt == 5'h02 |-> st_q.mem.wdata == st_q.gpr[0])
		else $error("first general register not saved at 40");
	a_link_write: assert property ($rose(st_q.fsm == S_LINK_WR) |->
		$past(st_q.kind) != K_JMP && $past(st_q.kind) != K_RET)
		else $error("back link written for jump or return");
	a_static_readonly: assert property (st_q.mem.req && st_q.mem.we |->
		st_q.fsm == S_SAVE || st_q.fsm == S_LINK_WR)
		else $error("write outside save or link step");
	a_limit_fault: assert property (st_q.fsm == S_CHECK && !bad_type
		&& !busy_bad && !priv_bad && lim_bad |=> fault_o.badseg
		&& st_q.fsm == S_IDLE)
		else $error("short limit not rejected");
	a_busy_reject: assert property (st_q.fsm == S_CHECK && !bad_type
		&& st_q.kind != K_RET && d_type == TYPE_BUSY |=> fault_o.prot
		&& st_q.stat[ST_PROT])
		else $error("busy task entered by call");
	a_priv_check: assert property (st_q.fsm == S_CHECK && !bad_type
		&& !busy_bad && priv_bad |=> fault_o.prot ##1 !st_q.mem.req)
		else $error("privilege check not enforced");

	c_switch_done: cover property (st_q.fsm == S_LOAD ##1 st_q.fsm == S_IDLE);
	c_return_path: cover property (st_q.fsm == S_LINK_RD ##[1:20]
		st_q.fsm == S_SAVE);
	c_debug_trap: cover property (fault_o.dbg);
	c_io_denied: cover property ($rose(st_q.stat[ST_IO]));
endmodule

//--- tsh_mem_model.sv
// memory partner holding state segments and descriptor tables
`timescale 1ns/1ps
module tsh_mem_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire tsh_pkg::tsh_mem_t req_bus,
	input wire logic slow,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	import tsh_pkg::*;

	// ***********************************
	// storage: one read/write page, contiguous words
	// ***********************************
	logic [31:0] mem [0:255];
	logic [1:0] cnt_q;

	// ***********************************
	// answer after one or four cycles, data only with ack
	// ***********************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 2'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (req_bus.req && !mem_ack) begin
				if (cnt_q == (slow ? 2'h3 : 2'h0)) begin
					cnt_q <= 2'h0;
					mem_ack <= 1'b1;
					mem_rdata <= mem[req_bus.addr[9:2]];
					if (req_bus.we)
						mem[req_bus.addr[9:2]] <= req_bus.wdata;
				end else
					cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule

//--- tb.sv
// self-checking bench for the task state segment handler
`timescale 1ns/1ps
module tb;
	import tsh_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic slow = 1'b0;
	logic hreadyout, hresp, mem_ack;
	logic [31:0] hrdata, mem_rdata, rd;
	tsh_mem_t mem_o;
	tsh_flt_t fault_o;
	int errors = 0;
	int samples_checked = 0;
	int i;
	int flt_n = 0;

	always #2 hclk = ~hclk;

	// fault pulses, one weighted count per kind
	always @(negedge hclk)
		flt_n <= flt_n + (fault_o.prot ? 1 : 0) + (fault_o.badseg ? 16 : 0)
			+ (fault_o.dbg ? 256 : 0);

	tsh_task_state_segment_handler tsh_task_state_segment_handler_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .mem_o(mem_o), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .fault_o(fault_o));

	tsh_mem_model tsh_mem_model_inst (
		.hclk(hclk), .hresetn(hresetn), .req_bus(mem_o), .slow(slow),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// ***********************************
	// reporting
	// ***********************************
	task automatic conclude();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// ***********************************
	// ahb-lite single word transfers
	// ***********************************
	task automatic wait_rdy();
		int n;
		logic r;
		n = 0;
		do begin
			@(negedge hclk);
			r = hreadyout;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end while (r !== 1'b1 && n < 40);
		if (r !== 1'b1) begin
			errors++;
			conclude();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		check("bus response", {31'h0, hresp}, 32'h0);
	endtask

	task automatic stat(input int b, input logic e);
		bus(1'b0, R_STATUS, 32'h0);
		check("status flag", {31'h0, rd[b]}, {31'h0, e});
		bus(1'b1, R_STATUS, 32'h1e);
	endtask

	task automatic sw(input logic [3:0] ctrl, input logic [15:0] sel,
		input logic [1:0] lvl, input logic [3:0] exp);
		int n;
		int f0;
		logic [31:0] fx;
		f0 = flt_n;
		fx = {20'h0, 3'h0, exp[2], 3'h0, exp[1], 3'h0, exp[0]};
		bus(1'b1, R_NEWSEL, {16'h0, sel});
		bus(1'b1, R_LVL, {30'h0, lvl});
		bus(1'b1, R_CTRL, {28'h0, ctrl});
		repeat (2) @(posedge hclk);
		n = 0;
		do begin
			bus(1'b0, R_STATUS, 32'h0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 200);
		if (rd[ST_BUSY] !== 1'b0) begin
			errors++;
			conclude();
		end
		check("switch status", rd, {27'h0, exp, 1'b0});
		check("fault pulses", 32'(flt_n - f0), fx);
		bus(1'b1, R_STATUS, 32'h1e);
	endtask

	// ***********************************
	// memory image helpers
	// ***********************************
	task automatic m(input logic [31:0] a, input logic [31:0] d);
		tsh_mem_model_inst.mem[a[9:2]] = d;
	endtask

	task automatic desc(input int k, input logic [31:0] b,
		input logic [19:0] l, input logic [1:0] p, input logic [3:0] t);
		m(32'h300 + 32'(k * 8), {b[15:0], l[15:0]});
		m(32'h304 + 32'(k * 8), {b[31:24], 4'h0, l[19:16], 1'b1, p, 1'b0,
			t, b[23:16]});
	endtask

	initial begin
		#200000;
		errors++;
		conclude();
	end

	// ***********************************
	// main sequence
	// ***********************************
	initial begin
		for (i = 0; i < 256; i++)
			m(32'(i * 4), 32'hffff_ffff);
		m(32'h01c, 32'h0000_7777);
		desc(1, 32'h100, 20'h67, 2'h0, TYPE_AVAIL);
		desc(2, 32'h280, 20'h66, 2'h0, TYPE_AVAIL);
		desc(3, 32'h180, 20'h67, 2'h0, TYPE_BUSY);
		desc(4, 32'h200, 20'h67, 2'h2, TYPE_AVAIL);
		for (i = 0; i < 6; i++)
			m(32'h104 + 32'(i * 4), 32'h5000 + 32'(i));
		m(32'h11c, 32'h0001_0000);
		m(32'h160, 32'h0000_0028);
		m(32'h164, 32'h0064_0001);
		m(32'h200, 32'h0000_0008);
		m(32'h264, 32'h0000_0000);
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, R_TRSEL, 32'h0);
		check("tr selector", rd, {16'h0, TR_SEL_RST});
		bus(1'b0, R_TRBASE, 32'h0);
		check("tr base", rd, TR_BASE_RST);
		bus(1'b0, R_TRLIM, 32'h0);
		check("tr limit", rd, TR_LIMIT_RST);
		bus(1'b0, 8'h34, 32'h0);
		check("unmapped read", rd, 32'h0);
		for (i = 0; i < 8; i++)
			bus(1'b1, R_GPR + 8'(i * 4), 32'h1111_0000 + 32'(i));
		for (i = 0; i < 6; i++)
			bus(1'b1, R_SEL + 8'(i * 4), 32'h0000_0a00 + 32'(i));
		bus(1'b1, R_FLAGS, 32'h0000_0202);
		bus(1'b1, R_IP, 32'h0000_4000);
		bus(1'b1, R_GTBL, 32'h0000_0300);
		sw(4'h3, 16'h0008, 2'h0, 4'h4);
		for (i = 0; i < 8; i++)
			check("saved gpr", tsh_mem_model_inst.mem[10 + i],
				32'h1111_0000 + 32'(i));
		for (i = 0; i < 6; i++)
			check("saved sel", tsh_mem_model_inst.mem[18 + i],
				32'h0000_0a00 + 32'(i));
		check("saved ip", tsh_mem_model_inst.mem[8], 32'h4000);
		check("saved flags", tsh_mem_model_inst.mem[9], 32'h202);
		check("back link", tsh_mem_model_inst.mem[64], 32'h0);
		check("old static", tsh_mem_model_inst.mem[7], 32'h7777);
		check("new page base", tsh_mem_model_inst.mem[71], 32'h10000);
		for (i = 0; i < 6; i++) begin
			bus(1'b0, R_STK + 8'(i * 4), 32'h0);
			check("stack", rd, 32'h5000 + 32'(i));
			check("stack mem", tsh_mem_model_inst.mem[65 + i],
				32'h5000 + 32'(i));
		end
		bus(1'b0, R_LDTSEL, 32'h0);
		check("local table sel", rd, 32'h28);
		bus(1'b0, R_PAGE, 32'h0);
		check("page base", rd, 32'h0001_0000);
		bus(1'b0, R_IOMAP, 32'h0);
		check("io map base", rd, 32'h64);
		bus(1'b0, R_TRLIM, 32'h0);
		check("new limit", rd, 32'h67);
		slow <= 1'b1;
		sw(4'h1, 16'h0010, 2'h0, 4'h2);
		sw(4'h5, 16'h0018, 2'h0, 4'h1);
		sw(4'h1, 16'h000c, 2'h0, 4'h1);
		sw(4'h3, 16'h0020, 2'h3, 4'h1);
		sw(4'hb, 16'h0020, 2'h0, 4'h1);
		m(32'h100, 32'h0000_000c);
		sw(4'h7, 16'h0000, 2'h0, 4'h2);
		m(32'h100, 32'h0000_0008);
		sw(4'h7, 16'h0000, 2'h0, 4'h2);
		bus(1'b0, R_TRSEL, 32'h0);
		check("tr kept", rd, 32'h8);
		desc(1, 32'h100, 20'h67, 2'h0, TYPE_BUSY);
		sw(4'h1, 16'h0020, 2'h2, 4'h0);
		check("jump link", tsh_mem_model_inst.mem[128], 32'h8);
		check("saved ip 2", tsh_mem_model_inst.mem[72], 32'h4000);
		bus(1'b0, R_TRBASE, 32'h0);
		check("tr base 2", rd, 32'h200);
		slow <= 1'b0;
		sw(4'h7, 16'h0000, 2'h0, 4'h4);
		bus(1'b0, R_TRSEL, 32'h0);
		check("return target", rd, 32'h8);
		check("return link", tsh_mem_model_inst.mem[64], 32'h8);
		bus(1'b1, R_SEGCHK, 32'h09);
		stat(ST_PROT, 1'b1);
		bus(1'b1, R_SEGCHK, 32'h0b);
		stat(ST_PROT, 1'b1);
		bus(1'b1, R_SEGCHK, 32'h19);
		stat(ST_PROT, 1'b0);
		bus(1'b1, R_IOCHK, 32'h3);
		stat(ST_IO, 1'b0);
		bus(1'b1, R_IOCHK, 32'h4);
		stat(ST_IO, 1'b1);
		bus(1'b1, R_TRSEL, 32'h55);
		bus(1'b0, R_TRSEL, 32'h0);
		check("tr read only", rd, 32'h8);
		conclude();
	end
endmodule
